// ---- src/acc_xfer_pkg.sv ----
// Package: opcodes, register map and types for the accumulator transfer executor
package acc_xfer_pkg;

	// ========================================
	// Instruction codes (10-bit words)
	localparam logic [9:0] OP_LOAD_POINTER_FROM_ACC       = 10'h029;
	localparam logic [9:0] OP_LOAD_PAIR_FROM_WORK_AND_ACC = 10'h01A;
	localparam logic [9:0] OP_LOAD_PORT_CFG0_FROM_ACC     = 10'h228;
	localparam logic [9:0] OP_LOAD_PORT_CFG1_FROM_ACC     = 10'h229;
	localparam logic [9:0] OP_LOAD_PORT_CFG2_FROM_ACC     = 10'h22A;
	localparam logic [9:0] OP_LOAD_PORT_CFG3_FROM_ACC     = 10'h22B;
	localparam int         NUM_PORT_CFG                   = 4;

	// ========================================
	// APB register byte offsets
	localparam logic [11:0] ADDR_INSTR    = 12'h000;
	localparam logic [11:0] ADDR_ACC      = 12'h004;
	localparam logic [11:0] ADDR_WORK     = 12'h008;
	localparam logic [11:0] ADDR_POINTER  = 12'h00C;
	localparam logic [11:0] ADDR_PAIR     = 12'h010;
	localparam logic [11:0] ADDR_PORT_CFG = 12'h014; // Four words from here
	localparam logic [11:0] ADDR_STATUS   = 12'h024;

	// ========================================
	// Status field positions
	localparam int STATUS_CARRY_BIT   = 0;
	localparam int STATUS_BADOP_BIT   = 1;

	// ========================================
	// Reset values
	localparam logic [9:0] RST_INSTR    = 10'h000;
	localparam logic [3:0] RST_NIBBLE   = 4'h0;
	localparam logic [2:0] RST_POINTER  = 3'h0;
	localparam logic [7:0] RST_PAIR     = 8'h00;

	// ========================================
	// Decoded operation
	typedef enum logic [2:0] {
		OPK_NONE    = 3'b000,
		OPK_POINTER = 3'b001,
		OPK_PAIR    = 3'b010,
		OPK_CFG     = 3'b011,
		OPK_BAD     = 3'b100
	} op_kind_t;

	// Pointer and pair transfer destinations seen by the core; port configurations are kept apart
	typedef struct packed {
		logic [7:0] pair;
		logic [2:0] pointer;
	} xfer_state_t;

endpackage : acc_xfer_pkg

// ---- src/accumulator_transfer_exec.sv ----
// Accumulator-sourced register transfer executor with an APB register port
`timescale 1ns/1ps
`default_nettype none

module accumulator_transfer_exec
	import acc_xfer_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  xfer_state_t xfer_state,
	output var  logic [3:0]  port_drive_cfg [NUM_PORT_CFG],
	output var  logic        carry_flag
);

	// ========================================
	// Storage
	// Accumulator and working register stand in for the core's own registers;
	// software loads them over the bus before issuing a transfer
	logic [9:0] instr;
	logic [3:0] acc;
	logic [3:0] work;
	logic       bad_opcode;

	// ========================================
	// Register map, one aligned word each, data in the low bits
	//   0x000  instruction word, write executes, read returns the last one issued
	//   0x004  accumulator, four bits, read and write
	//   0x008  second working register, four bits, read and write
	//   0x00C  pointer, three bits, read only
	//   0x010  pair register, eight bits, read only
	//   0x014  port drive configuration 0 to 3, four words, read only
	//   0x024  status: bit 0 carry, bit 1 sticky unknown-opcode flag
	// Unmapped words read zero and answer with an error.
	// Destinations are read only so that only an instruction can move them;
	// a stray bus write would otherwise hide a broken transfer.

	// ========================================
	// Bus decode
	wire logic [11:0] word_addr = {paddr[11:2], 2'b00};
	wire logic        setup     = psel & ~penable;
	wire logic        commit    = psel & penable & pready;
	wire logic        wr_commit = commit & pwrite;

	// Word hits; the two low address bits are ignored
	wire logic        hit_instr = (word_addr == ADDR_INSTR);
	wire logic        hit_acc   = (word_addr == ADDR_ACC);
	wire logic        hit_work  = (word_addr == ADDR_WORK);
	wire logic        hit_ptr   = (word_addr == ADDR_POINTER);
	wire logic        hit_pair  = (word_addr == ADDR_PAIR);
	wire logic        hit_stat  = (word_addr == ADDR_STATUS);

	// Port configuration block: four words, picked by bits three and two of the offset from ADDR_PORT_CFG
	wire logic [11:0] cfg_off   = word_addr - ADDR_PORT_CFG;
	wire logic        hit_cfg   = (word_addr >= ADDR_PORT_CFG) & (cfg_off[11:4] == 8'h00);
	wire logic [1:0]  cfg_sel   = cfg_off[3:2];
	wire logic        mapped    = hit_instr | hit_acc | hit_work | hit_ptr | hit_pair
	                              | hit_stat | hit_cfg;
	// Read-only words refuse writes with an error so software sees the mistake
	wire logic        ro_hit    = hit_ptr | hit_pair | hit_cfg;
	wire logic        next_err  = ~mapped | (pwrite & ro_hit);

	// ========================================
	// Instruction decode: a write to the instruction word executes it in that one cycle
	// Operands are the register values before the commit edge, so loading the
	// accumulator and issuing a transfer must be two separate bus accesses.
	// Any other code raises the unknown-opcode flag and is kept as the last instruction, but moves no destination.
	wire logic       issue  = wr_commit & hit_instr;
	wire logic [9:0] opcode = pwdata[9:0];
	op_kind_t        kind;
	logic [1:0]      cfg_idx;
	always_comb begin
		kind    = OPK_BAD;
		cfg_idx = 2'h0;
		case (opcode)
			OP_LOAD_POINTER_FROM_ACC:       kind = OPK_POINTER;
			OP_LOAD_PAIR_FROM_WORK_AND_ACC: kind = OPK_PAIR;
			OP_LOAD_PORT_CFG0_FROM_ACC: begin
				kind    = OPK_CFG;
				cfg_idx = 2'h0;
			end
			OP_LOAD_PORT_CFG1_FROM_ACC: begin
				kind    = OPK_CFG;
				cfg_idx = 2'h1;
			end
			OP_LOAD_PORT_CFG2_FROM_ACC: begin
				kind    = OPK_CFG;
				cfg_idx = 2'h2;
			end
			OP_LOAD_PORT_CFG3_FROM_ACC: begin
				kind    = OPK_CFG;
				cfg_idx = 2'h3;
			end
			default:                        kind = OPK_BAD;
		endcase
	end

	// Execute strobes, at most one high per commit
	wire logic       do_ptr  = issue & (kind == OPK_POINTER);
	wire logic       do_pair = issue & (kind == OPK_PAIR);
	wire logic       do_cfg  = issue & (kind == OPK_CFG);
	wire logic       do_bad  = issue & (kind == OPK_BAD);

	// Next destination values
	wire logic [2:0] next_ptr  = acc[2:0];    // Top accumulator bit dropped
	wire logic [7:0] next_pair = {work, acc}; // Both nibbles in one edge

	// Read words, zero-extended to the bus width
	wire logic [31:0] rd_instr = {22'h0, instr};
	wire logic [31:0] rd_acc   = {28'h0, acc};
	wire logic [31:0] rd_work  = {28'h0, work};
	wire logic [31:0] rd_ptr   = {29'h0, xfer_state.pointer};
	wire logic [31:0] rd_pair  = {24'h0, xfer_state.pair};
	wire logic [31:0] rd_cfg   = {28'h0, port_drive_cfg[cfg_sel]};
	wire logic [31:0] rd_stat  = {30'h0, bad_opcode, carry_flag};

	// Read mux; an unmapped word falls through to zero
	wire logic [31:0] next_rdata =
		hit_instr ? rd_instr :
		hit_acc   ? rd_acc :
		hit_work  ? rd_work :
		hit_ptr   ? rd_ptr :
		hit_pair  ? rd_pair :
		hit_cfg   ? rd_cfg :
		hit_stat  ? rd_stat : 32'h0;

	// Status write: carry written directly, bad-opcode cleared by writing one
	wire logic stat_wr   = wr_commit & hit_stat;
	wire logic clr_bad   = stat_wr & pwdata[STATUS_BADOP_BIT];

	// Sticky flag: a new unknown opcode in the clearing cycle still sets it,
	// so software never loses an error that arrived while it was clearing
	wire logic next_bad  = do_bad | (bad_opcode & ~clr_bad);

	// ========================================
	// APB handshake: one wait-free access, answer registered in the setup cycle
	// Ready rises for exactly the access cycle after each setup; read data is
	// captured at setup and then holds, so a slow master still sees it.
	// Limitation: a low clock enable also freezes ready, so a master must not
	// start an access while the enable is low.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (clk_en) begin
			pready  <= setup;
			pslverr <= setup & next_err;
			if (setup) begin
				prdata <= pwrite ? 32'h0 : next_rdata;
			end
		end
	end

	// Software-written registers; writes to bad addresses land nowhere
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= RST_INSTR;
			acc   <= RST_NIBBLE;
			work  <= RST_NIBBLE;
		end else if (clk_en) begin
			if (issue) instr <= opcode;
			if (wr_commit & hit_acc) acc <= pwdata[3:0];
			if (wr_commit & hit_work) work <= pwdata[3:0];
		end
	end

	// Carry only moves on a status write; transfers leave it alone
	// Bad-opcode flag: a new set in the clear cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_flag <= 1'b0;
			bad_opcode <= 1'b0;
		end else if (clk_en) begin
			if (stat_wr) carry_flag <= pwdata[STATUS_CARRY_BIT];
			bad_opcode <= next_bad;
		end
	end

	// Pointer and pair destinations, one machine cycle each
	// Each destination loads whole at one edge, so no half-updated value shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_state.pointer <= RST_POINTER;
			xfer_state.pair    <= RST_PAIR;
		end else if (clk_en) begin
			if (do_ptr) xfer_state.pointer <= next_ptr;
			if (do_pair) xfer_state.pair <= next_pair;
		end
	end

	// ========================================
	// Port output-structure control registers, whole accumulator copied
	// One register per port; the pins that use them live outside this block
	for (genvar g = 0; g < NUM_PORT_CFG; g++) begin : g_cfg
		wire logic load = do_cfg & (cfg_idx == 2'(g));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				port_drive_cfg[g] <= RST_NIBBLE;
			end else if (clk_en & load) begin
				port_drive_cfg[g] <= acc;
			end
		end
	end

endmodule : accumulator_transfer_exec

`default_nettype wire

// ---- testbench/acc_xfer_monitor.sv ----
// Port checker for the accumulator transfer executor
`timescale 1ns/1ps
`default_nettype none
module acc_xfer_monitor
	import acc_xfer_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire xfer_state_t xfer_state,
	input wire logic [3:0]  port_drive_cfg [NUM_PORT_CFG],
	input wire logic        carry_flag
);
	// ========================================
	// Commit decode; acc and work are rebuilt from bus writes
	wire       wcom = psel && penable && pready && clk_en && pwrite;
	wire [9:0] wadr = paddr[11:2];
	wire       wins = wcom && wadr == ADDR_INSTR[11:2];
	wire [9:0] op   = pwdata[9:0];
	logic [3:0] acc_m;
	logic [3:0] work_m;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_m  <= RST_NIBBLE;
			work_m <= RST_NIBBLE;
		end else if (wcom) begin
			if (wadr == ADDR_ACC[11:2]) acc_m <= pwdata[3:0];
			if (wadr == ADDR_WORK[11:2]) work_m <= pwdata[3:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ========================================
	// Transfers land one edge after the instruction commits
	a_pointer_load: assert property (wins && op == OP_LOAD_POINTER_FROM_ACC
		|=> xfer_state.pointer == acc_m[2:0]) else $error("pointer load wrong");
	a_pointer_hold: assert property (!wins |=> $stable(xfer_state.pointer))
		else $error("pointer changed");
	a_ro_refused: assert property (wcom && wadr == ADDR_POINTER[11:2] |-> pslverr)
		else $error("pointer write accepted");
	a_pair_high: assert property (wins && op == OP_LOAD_PAIR_FROM_WORK_AND_ACC
		|=> xfer_state.pair[7:4] == work_m) else $error("pair high wrong");
	a_pair_low: assert property (wins && op == OP_LOAD_PAIR_FROM_WORK_AND_ACC
		|=> xfer_state.pair[3:0] == acc_m) else $error("pair low wrong");
	for (genvar n = 0; n < NUM_PORT_CFG; n++) begin : g_cfg
		a_cfg_load: assert property (wins && op == OP_LOAD_PORT_CFG0_FROM_ACC + n
			|=> port_drive_cfg[n] == acc_m) else $error("port cfg wrong");
	end
	a_carry_kept: assert property (wins |=> $stable(carry_flag))
		else $error("carry touched");
	a_ready_next: assert property (psel && !penable && clk_en |=> pready)
		else $error("no single cycle answer");
	cover property (wins && op == OP_LOAD_POINTER_FROM_ACC);
	cover property (wins && op == OP_LOAD_PAIR_FROM_WORK_AND_ACC);
	cover property (wins && op == OP_LOAD_PORT_CFG3_FROM_ACC);
endmodule : acc_xfer_monitor
`default_nettype wire

// ---- testbench/accumulator_transfer_exec_tb_top.sv ----
// Directed bench for the accumulator transfer executor
`timescale 1ns/1ps
`default_nettype none
module accumulator_transfer_exec_tb_top
	import acc_xfer_pkg::*;
;
	logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdat;
	logic        pready, pslverr, carry, rerr;
	xfer_state_t xs;
	logic [3:0]  cfg [NUM_PORT_CFG];
	int          bad_count = 0, total_checks = 0;
	always #5 pclk = ~pclk;
	accumulator_transfer_exec accumulator_transfer_exec_i (.pclk, .presetn, .clk_en, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_state(xs),
		.port_drive_cfg(cfg), .carry_flag(carry));
	// ========================================
	// Bus tasks; the request holds until pready is seen, then releases at that edge
	task automatic close_out();
		if (bad_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : close_out
	task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : cmp
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		int i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Ready and the answer are read at the edge, before that edge's updates
		while (pready !== 1'b1 && i < 20) begin
			@(posedge pclk);
			i++;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			bad_count++;
			close_out();
		end
	endtask : xfer
	task automatic rd(logic [11:0] a, logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		cmp("prdata", e, rdat);
	endtask : rd
	task automatic run(logic [9:0] op);
		xfer(1'b1, ADDR_INSTR, {22'h0, op});
		@(posedge pclk); // Let the commit edge's update settle before any compare
	endtask : run
	// ========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_PAIR, 32'h0);
		xfer(1'b1, ADDR_ACC, 32'hD);
		xfer(1'b1, ADDR_WORK, 32'hA);
		run(OP_LOAD_POINTER_FROM_ACC);
		rd(ADDR_POINTER, 32'h5);
		xfer(1'b1, ADDR_ACC, 32'h6);
		run(OP_LOAD_PAIR_FROM_WORK_AND_ACC);
		cmp("pair", 32'hA6, {24'h0, xs.pair});
		for (int n = 0; n < 4; n++) begin
			xfer(1'b1, ADDR_ACC, 32'h9 + n);
			run(OP_LOAD_PORT_CFG0_FROM_ACC + 10'(n));
			cmp("cfg", 32'h9 + n, {28'h0, cfg[n]});
		end
		cmp("cfg0", 32'h9, {28'h0, cfg[0]});
		xfer(1'b1, ADDR_STATUS, 32'h1);
		run(OP_LOAD_POINTER_FROM_ACC);
		cmp("carry", 32'h1, {31'h0, carry});
		xfer(1'b1, ADDR_POINTER, 32'h0);
		cmp("pslverr", 32'h1, {31'h0, rerr});
		rd(ADDR_POINTER, 32'h4);
		// Unknown opcode: the sticky flag and the instruction word move, carry and pointer stay
		run(10'h3FF);
		rd(ADDR_STATUS, 32'h3);
		rd(ADDR_POINTER, 32'h4);
		rd(ADDR_INSTR, 32'h3FF);
		xfer(1'b1, ADDR_STATUS, 32'h3);
		rd(ADDR_STATUS, 32'h1);
		rd(12'h3F0, 32'h0);
		cmp("pslverr", 32'h1, {31'h0, rerr});
		// Mid-run reset: destinations and carry return to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		cmp("cfg0", 32'h0, {28'h0, cfg[0]});
		cmp("carry", 32'h0, {31'h0, carry});
		presetn <= 1'b1;
		rd(ADDR_POINTER, 32'h0);
		close_out();
	end
endmodule : accumulator_transfer_exec_tb_top
bind accumulator_transfer_exec acc_xfer_monitor acc_xfer_monitor_i (.pclk, .presetn, .clk_en,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .xfer_state,
	.port_drive_cfg, .carry_flag);
`default_nettype wire
